// [rtl/pct_countdown.sv]
// Pedestrian countdown timer: learns clearance time and counts it down on two digits
//
// Summary of operation
// - Count down from flashing hand; blank at steady
// - Clearance countdown only; start at measured clearance
// - No user inputs; timing learned from indications
// - One dark learning cycle after power-on
// - Timing change: blank, relearn one dark cycle
// - Back-to-back walk cycles counted correctly
// - Preempted walk: follow to flashing, count
// - Preemption during flashing: keep counting
// - Preempted cycle overwrites learned duration only in a learning cycle
// - Early steady hand stops timing, blanks
// - Hand and walk both dark: suspend, blank
// - Outage over 1.5 s: one dark cycle
// - Two seven-segment decimal digits show count
// - Constant intensity; dark at once on supply loss
`timescale 1ns/10ps
module pct_countdown #(
  parameter int MS_CYCLES = pct_pkg::MS_CYCLES,                          // Clocks per millisecond
  parameter int DEB_CYCLES = pct_pkg::DEBOUNCE_MS * pct_pkg::MS_CYCLES   // Debounce window in clocks
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_walk,
  input wire logic i_hand,
  input wire logic i_power_ok,
  output logic [6:0] o_seg_tens,
  output logic [6:0] o_seg_ones,
  output logic o_count_on
);
  localparam int SW = pct_pkg::SEC_W;

  // Segment pattern for one decimal digit, bits g..a
  function automatic logic [6:0] seg7(input logic [3:0] d);
    case (d)
      4'h0: seg7 = 7'h3f;
      4'h1: seg7 = 7'h06;
      4'h2: seg7 = 7'h5b;
      4'h3: seg7 = 7'h4f;
      4'h4: seg7 = 7'h66;
      4'h5: seg7 = 7'h6d;
      4'h6: seg7 = 7'h7d;
      4'h7: seg7 = 7'h07;
      4'h8: seg7 = 7'h7f;
      4'h9: seg7 = 7'h6f;
      default: seg7 = pct_pkg::SEG_OFF;
    endcase
  endfunction : seg7

  pct_ind_if ind (); // Cleaned indications

  // Only the indications steer timing; there are no setting inputs at all
  pct_debounce #(.DEB_CYCLES(DEB_CYCLES)) u_deb (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_raw({i_hand, i_walk}),
    .ind(ind)
  );

  pct_pkg::pct_state_t state_q; // Where in the pedestrian cycle we are
  logic walk_prev_q;            // Walk level one cycle ago
  logic hand_prev_q;            // Hand level one cycle ago
  logic [pct_pkg::MS_CNT_W-1:0] ms_cnt_q; // Free running millisecond divider
  logic [pct_pkg::MSC_W-1:0] sec_ms_q;    // Milliseconds into current second
  logic [pct_pkg::MSC_W-1:0] hand_on_q;   // Milliseconds hand has been lit
  logic [pct_pkg::MSC_W-1:0] hand_off_q;  // Milliseconds hand has been dark
  logic [pct_pkg::MSC_W-1:0] outage_q;    // Milliseconds supply has been lost
  logic [SW-1:0] meas_q;        // Seconds since clearance began
  logic [SW-1:0] last_rise_q;   // Clearance second of latest hand onset
  logic [SW-1:0] walk_len_q;    // Seconds of walk in this cycle
  logic [SW-1:0] learned_q;     // Stored clearance duration
  logic [SW-1:0] learned_walk_q;// Stored walk duration
  logic learned_ok_q;           // A duration has been stored
  logic relearn_q;              // Change seen, next cycle relearns
  logic pend_q;                 // One short cycle seen, awaiting a second
  logic dark_req_q;             // Outage seen, next cycle stays dark
  logic cyc_learn_q;            // This cycle is a learning cycle
  logic cyc_dark_q;             // This cycle shows no count
  logic [SW-1:0] count_q;       // Value on the display
  logic [6:0] seg_tens_q;       // Registered tens pattern
  logic [6:0] seg_ones_q;       // Registered ones pattern
  logic count_on_q;             // Digits lit

  // Decoded events
  logic ms_tick, sec_tick, walk_rise, hand_rise, steady, dark_both, enter_walk, enter_clear, end_ok;
  logic [SW-1:0] measured;      // Clearance length of the cycle that is ending
  logic is_long, is_short;

  assign ms_tick = (ms_cnt_q == pct_pkg::MS_CNT_W'(MS_CYCLES - 1));
  assign sec_tick = ms_tick && (sec_ms_q == pct_pkg::MSC_W'(pct_pkg::SEC_MS - 1));
  assign walk_rise = ind.walk && !walk_prev_q;
  assign hand_rise = ind.hand && !hand_prev_q;
  // Hand lit past a flash on phase means steady; shorter gaps are flash off phases
  assign steady = (hand_on_q >= pct_pkg::MSC_W'(pct_pkg::STEADY_MS));
  assign dark_both = !ind.walk && (hand_off_q >= pct_pkg::MSC_W'(pct_pkg::DARK_MS));
  assign enter_walk = walk_rise && (state_q != pct_pkg::PCT_ST_WALK);
  assign enter_clear = (state_q == pct_pkg::PCT_ST_WALK) && !ind.walk && ind.hand;
  // A cycle completes on steady hand or on a new walk without steady hand
  assign end_ok = (state_q == pct_pkg::PCT_ST_CLEAR) && (ind.walk || steady);
  assign measured = ind.walk ? meas_q : last_rise_q;
  assign is_long = (measured > learned_q + pct_pkg::TOL_S);
  assign is_short = (measured + pct_pkg::TOL_S < learned_q);

  // Cycle tracker
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      state_q <= pct_pkg::PCT_ST_IDLE;
    end else begin
      case (state_q)
        pct_pkg::PCT_ST_IDLE: begin
          if (walk_rise) begin
            state_q <= pct_pkg::PCT_ST_WALK;
          end
        end
        pct_pkg::PCT_ST_WALK: begin
          if (enter_clear) begin
            state_q <= pct_pkg::PCT_ST_CLEAR; // Walk may be cut short by preemption
          end else if (!ind.walk && !ind.hand) begin
            state_q <= pct_pkg::PCT_ST_IDLE;
          end
        end
        pct_pkg::PCT_ST_CLEAR: begin
          if (ind.walk) begin
            state_q <= pct_pkg::PCT_ST_WALK;
          end else if (steady || dark_both) begin
            state_q <= pct_pkg::PCT_ST_IDLE;
          end
        end
        default: state_q <= pct_pkg::PCT_ST_IDLE;
      endcase
    end
  end

  // Edge history and the millisecond and second time base
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      walk_prev_q <= 1'b0;
      hand_prev_q <= 1'b0;
      ms_cnt_q <= '0;
      sec_ms_q <= '0;
    end else begin
      walk_prev_q <= ind.walk;
      hand_prev_q <= ind.hand;
      ms_cnt_q <= ms_tick ? '0 : ms_cnt_q + 1'b1;
      // Seconds are aligned to the start of each interval so counts are whole seconds
      if (enter_walk || enter_clear) begin
        sec_ms_q <= '0;
      end else if (ms_tick) begin
        sec_ms_q <= sec_tick ? '0 : sec_ms_q + 1'b1;
      end
    end
  end

  // Hand lit and dark durations, and supply outage length
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      hand_on_q <= '0;
      hand_off_q <= '0;
      outage_q <= '0;
    end else begin
      if (!ind.hand) begin
        hand_on_q <= '0;
      end else if (ms_tick && !steady) begin
        hand_on_q <= hand_on_q + 1'b1;
      end
      if (ind.hand) begin
        hand_off_q <= '0;
      end else if (ms_tick && hand_off_q < pct_pkg::MSC_W'(pct_pkg::DARK_MS)) begin
        hand_off_q <= hand_off_q + 1'b1;
      end
      if (i_power_ok) begin
        outage_q <= '0;
      end else if (ms_tick && outage_q <= pct_pkg::MSC_W'(pct_pkg::OUTAGE_MS)) begin
        outage_q <= outage_q + 1'b1;
      end
    end
  end

  // Measurement of walk and clearance lengths in whole seconds
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      meas_q <= '0;
      last_rise_q <= '0;
      walk_len_q <= '0;
    end else begin
      if (enter_walk) begin
        walk_len_q <= '0;
      end else if (state_q == pct_pkg::PCT_ST_WALK && sec_tick && walk_len_q != pct_pkg::SEC_MAX) begin
        walk_len_q <= walk_len_q + 1'b1;
      end
      if (enter_clear) begin
        meas_q <= '0;
        last_rise_q <= '0;
      end else if (state_q == pct_pkg::PCT_ST_CLEAR) begin
        if (sec_tick && meas_q != pct_pkg::SEC_MAX) begin
          meas_q <= meas_q + 1'b1;
        end
        // The onset of the steady hand closes the clearance
        if (hand_rise) begin
          last_rise_q <= meas_q;
        end
      end
    end
  end

  // Learning, change detection and preemption handling
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      learned_q <= '0;
      learned_walk_q <= '0;
      learned_ok_q <= 1'b0;
      relearn_q <= 1'b0;
      pend_q <= 1'b0;
      dark_req_q <= 1'b0;
      cyc_learn_q <= 1'b0;
      cyc_dark_q <= 1'b1;
    end else begin
      // Set wins over the consume at walk start so a fresh outage is never lost
      // Only a loss strictly longer than the limit counts; the counter stops one step past it
      if (outage_q > pct_pkg::MSC_W'(pct_pkg::OUTAGE_MS)) begin
        dark_req_q <= 1'b1;
      end else if (enter_walk) begin
        dark_req_q <= 1'b0;
      end
      if (end_ok && cyc_learn_q) begin
        // Learning cycle complete: store what was seen
        learned_q <= measured;
        learned_walk_q <= walk_len_q;
        learned_ok_q <= 1'b1;
        relearn_q <= 1'b0;
        pend_q <= 1'b0;
      end else if (end_ok && learned_ok_q && !cyc_dark_q && walk_len_q >= learned_walk_q) begin
        // A full-length walk means no preemption; a short walk leaves the store alone
        if (is_long || (is_short && pend_q)) begin
          relearn_q <= 1'b1;
        end
        // One short clearance may be a preemption in the flashing hand; a second confirms a change
        pend_q <= is_short && !pend_q;
      end else if (state_q == pct_pkg::PCT_ST_CLEAR && !cyc_learn_q && meas_q > learned_q + pct_pkg::TOL_S) begin
        // Flashing outlasts the learned clearance: timing grew, blank now
        relearn_q <= 1'b1;
      end
      if (enter_walk) begin
        // Every cycle starting after reset or a change is a dark learning cycle
        // A learning cycle closing on this very walk has just stored, so the new cycle counts
        cyc_learn_q <= (relearn_q || !learned_ok_q) && !(end_ok && cyc_learn_q);
        cyc_dark_q <= dark_req_q || ((relearn_q || !learned_ok_q) && !(end_ok && cyc_learn_q));
      end
    end
  end

  // Countdown value: loaded at flashing-hand start, one step per second to zero
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      count_q <= '0;
    end else if (enter_clear) begin
      // Always from the stored duration, even after a preempted cycle
      count_q <= (learned_q > pct_pkg::DISP_MAX) ? pct_pkg::DISP_MAX : learned_q;
    end else if (state_q == pct_pkg::PCT_ST_CLEAR && sec_tick && count_q != pct_pkg::SEC_ZERO) begin
      count_q <= count_q - 1'b1; // Runs straight through any preemption
    end
  end

  // Display registers: lit only while counting a normal cycle
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      count_on_q <= 1'b0;
      seg_tens_q <= pct_pkg::SEG_OFF;
      seg_ones_q <= pct_pkg::SEG_OFF;
    end else begin
      // Leaving clearance blanks the digits, as does a change or a dark cycle
      count_on_q <= (state_q == pct_pkg::PCT_ST_CLEAR) && !cyc_dark_q && !relearn_q;
      if ((state_q == pct_pkg::PCT_ST_CLEAR) && !cyc_dark_q && !relearn_q) begin
        // Tens digit blank below ten; ones always shown, down to 0
        seg_tens_q <= (count_q < SW'(pct_pkg::DIGIT_BASE)) ? pct_pkg::SEG_OFF
                      : seg7(4'(count_q / SW'(pct_pkg::DIGIT_BASE)));
        seg_ones_q <= seg7(4'(count_q % SW'(pct_pkg::DIGIT_BASE)));
      end else begin
        seg_tens_q <= pct_pkg::SEG_OFF;
        seg_ones_q <= pct_pkg::SEG_OFF;
      end
    end
  end

  // Full on or off, never dimmed; supply loss darkens outputs in the same instant
  assign o_seg_tens = i_power_ok ? seg_tens_q : pct_pkg::SEG_OFF;
  assign o_seg_ones = i_power_ok ? seg_ones_q : pct_pkg::SEG_OFF;
  assign o_count_on = count_on_q && i_power_ok;
endmodule : pct_countdown

// [include/pct_pkg.sv]
// Package of constants shared by the pedestrian countdown timer design
package pct_pkg;
  // Clock and time base
  localparam int CLK_PERIOD_NS = 10;                               // 100 MHz system clock
  localparam int MS_TIME_NS = 1000000;                             // One millisecond in ns
  localparam int MS_CYCLES = MS_TIME_NS / CLK_PERIOD_NS;           // Clocks per millisecond
  localparam int MS_CNT_W = 17;                                    // Holds MS_CYCLES - 1
  localparam int SEC_MS = 1000;                                    // Milliseconds per second
  // Indication timing thresholds, in milliseconds
  localparam int DEBOUNCE_MS = 20;                                 // Input must be stable this long
  localparam int DEB_CNT_W = 21;                                   // Holds debounce cycle count
  localparam int STEADY_MS = 1200;                                 // Hand on longer than this is steady
  localparam int DARK_MS = 1200;                                   // Hand off longer than this is dark
  localparam int OUTAGE_MS = 1500;                                 // Supply loss that forces a dark cycle
  localparam int MSC_W = 11;                                       // Millisecond counter width
  // Count widths and limits
  localparam int SEC_W = 8;                                        // Measured seconds width
  localparam logic [SEC_W-1:0] SEC_MAX = 8'hff;                    // Measurement saturates here
  localparam logic [SEC_W-1:0] DISP_MAX = 8'h63;                   // Two digits show at most 99
  localparam logic [SEC_W-1:0] TOL_S = 8'h01;                      // Tolerated measuring jitter
  localparam logic [SEC_W-1:0] SEC_ZERO = 8'h00;                   // Zero seconds
  localparam logic [3:0] DIGIT_BASE = 4'ha;                        // Decimal digit base
  localparam logic [6:0] SEG_OFF = 7'h00;                          // All segments dark
  localparam int NUM_IND = 2;                                      // Debounced indications
  localparam int IND_WALK = 0;                                     // Walking person bit
  localparam int IND_HAND = 1;                                     // Upraised hand bit
  // Cycle tracker states
  typedef enum logic [1:0] {
    PCT_ST_IDLE,
    PCT_ST_WALK,
    PCT_ST_CLEAR
  } pct_state_t;
endpackage : pct_pkg

// [include/pct_ind_if.sv]
// Interface carrying the cleaned pedestrian indications between modules
`timescale 1ns/10ps
interface pct_ind_if;
  logic walk; // Walking person lit
  logic hand; // Upraised hand lit (steady or in a flash on phase)
  modport drv (output walk, output hand);
  modport use_side (input walk, input hand);
endinterface : pct_ind_if

// [rtl/pct_debounce.sv]
// Debouncer that cleans the controller indication inputs
`timescale 1ns/10ps
module pct_debounce #(
  parameter int DEB_CYCLES = pct_pkg::DEBOUNCE_MS * pct_pkg::MS_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [pct_pkg::NUM_IND-1:0] i_raw,
  pct_ind_if.drv ind
);
  wire logic [pct_pkg::NUM_IND-1:0] clean; // Accepted levels, one bit from each filter

  // One filter per indication: a new level is taken only after it held for the full window
  for (genvar g = 0; g < pct_pkg::NUM_IND; g++) begin : g_filt
    logic [pct_pkg::DEB_CNT_W-1:0] cnt_q; // Cycles the raw level has differed
    logic lvl_q; // Accepted level, owned by this filter alone so no bit has two writers
    always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
        cnt_q <= '0;
        lvl_q <= 1'b0;
      end else if (i_raw[g] == lvl_q) begin
        // Glitch ended before the window, start over
        cnt_q <= '0;
      end else if (cnt_q == pct_pkg::DEB_CNT_W'(DEB_CYCLES - 1)) begin
        cnt_q <= '0;
        lvl_q <= i_raw[g];
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
    assign clean[g] = lvl_q;
  end

  assign ind.walk = clean[pct_pkg::IND_WALK];
  assign ind.hand = clean[pct_pkg::IND_HAND];
endmodule : pct_debounce

// [testbench/pct_countdown_props.sv]
// Port-level assertions for the pedestrian countdown timer
`timescale 1ns/10ps
module pct_countdown_props #(
  parameter int MS_CYCLES = pct_pkg::MS_CYCLES, // Clocks per millisecond
  parameter int DEB_CYCLES = pct_pkg::DEBOUNCE_MS * pct_pkg::MS_CYCLES // Debounce window
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_walk,
  input wire logic i_hand,
  input wire logic i_power_ok,
  input wire logic [6:0] o_seg_tens,
  input wire logic [6:0] o_seg_ones,
  input wire logic o_count_on
);
  // Digit patterns {g,f,e,d,c,b,a} for 0 to 9
  localparam logic [6:0] PAT [10] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d, 7'h07, 7'h7f, 7'h6f};
  // Margin past the debouncer and the output registers
  localparam int WALK_CYC = DEB_CYCLES + 4;
  // A hand lit, or both dark, this long must have blanked the digits
  localparam int LONG_CYC = pct_pkg::STEADY_MS * MS_CYCLES + DEB_CYCLES + 4;
  int hand_run_q; // Consecutive clocks with the hand lit
  int walk_run_q; // Consecutive clocks with the walker lit
  int dark_run_q; // Consecutive clocks with both dark
  int cnt_val; // Decoded two-digit value
  // Decode a digit; blank decodes as zero
  function automatic int seg_val(input logic [6:0] s);
    int v;
    v = 0;
    for (int i = 0; i < 10; i++) begin
      if (s == PAT[i]) v = i;
    end
    return v;
  endfunction : seg_val
  // True for a legal decimal digit pattern
  function automatic bit seg_ok(input logic [6:0] s);
    bit ok;
    ok = 1'b0;
    for (int i = 0; i < 10; i++) begin
      if (s == PAT[i]) ok = 1'b1;
    end
    return ok;
  endfunction : seg_ok
  always_comb begin
    cnt_val = seg_val(o_seg_tens) * 10 + seg_val(o_seg_ones);
  end
  // Run-length counters, saturating so that long phases cannot wrap
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      hand_run_q <= 0;
      walk_run_q <= 0;
      dark_run_q <= 0;
    end else begin
      hand_run_q <= !i_hand ? 0 : (hand_run_q > LONG_CYC ? hand_run_q : hand_run_q + 1);
      walk_run_q <= !i_walk ? 0 : (walk_run_q > LONG_CYC ? walk_run_q : walk_run_q + 1);
      dark_run_q <= (i_hand || i_walk) ? 0 : (dark_run_q > LONG_CYC ? dark_run_q : dark_run_q + 1);
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  a_dark_power_off: assert property (!i_power_ok |-> !o_count_on && o_seg_tens == 7'h00 && o_seg_ones == 7'h00)
    else $error("outputs lit while supply is lost");
  a_blank_segments: assert property (!o_count_on |-> o_seg_tens == 7'h00 && o_seg_ones == 7'h00)
    else $error("segments lit while display is off");
  a_ones_digit: assert property (o_count_on |-> seg_ok(o_seg_ones))
    else $error("ones digit pattern illegal");
  a_tens_digit: assert property (o_count_on |-> o_seg_tens == 7'h00 || (seg_ok(o_seg_tens) && o_seg_tens != PAT[0]))
    else $error("tens digit pattern illegal");
  a_step_down: assert property (o_count_on && $past(o_count_on) |-> cnt_val == $past(cnt_val) || cnt_val == $past(cnt_val) - 1)
    else $error("count moved other than down by one");
  a_walk_blank: assert property (walk_run_q > WALK_CYC |-> !o_count_on)
    else $error("count shown during walk");
  a_steady_blank: assert property (hand_run_q > LONG_CYC |-> !o_count_on)
    else $error("count shown during steady hand");
  a_dark_blank: assert property (dark_run_q > LONG_CYC |-> !o_count_on)
    else $error("count shown with both indications dark");
  c_count_three: cover property (o_count_on && cnt_val == 3);
  c_steady_end: cover property (o_count_on ##1 !o_count_on && i_hand);
  c_power_cut: cover property (o_count_on ##1 !i_power_ok);
endmodule : pct_countdown_props
bind pct_countdown pct_countdown_props #(.MS_CYCLES(MS_CYCLES), .DEB_CYCLES(DEB_CYCLES)) u_props (
  .i_clk(i_clk), .i_reset(i_reset), .i_walk(i_walk), .i_hand(i_hand), .i_power_ok(i_power_ok),
  .o_seg_tens(o_seg_tens), .o_seg_ones(o_seg_ones), .o_count_on(o_count_on));

// [testbench/pct_ctl_model.sv]
// Behavioural signal controller driving the pedestrian indications
`timescale 1ns/10ps
module pct_ctl_model #(
  parameter int MS_CYCLES = 2 // Clocks per millisecond
) (
  input wire logic i_clk,
  output logic o_walk,
  output logic o_hand
);
  localparam int FLASH_MS = 500; // Half period of the flashing hand
  // Both indications dark until the first phase
  initial begin
    o_walk = 1'b0;
    o_hand = 1'b0;
  end
  // Hold one indication pattern; called at a falling edge so levels change off the sampling edge
  task automatic show(input logic w, input logic h, input int ms);
    o_walk = w;
    o_hand = h;
    repeat (ms * MS_CYCLES) @(negedge i_clk);
  endtask : show
  // Flashing hand, lit first; a short last phase lets steady hand start after an off phase
  task automatic clear(input int ms);
    for (int t = 0; t < ms; t += FLASH_MS) begin
      show(1'b0, ((t / FLASH_MS) % 2) == 0, (ms - t < FLASH_MS) ? ms - t : FLASH_MS);
    end
  endtask : clear
endmodule : pct_ctl_model

// [testbench/tb.sv]
// Self-checking bench for the pedestrian countdown timer
`timescale 1ns/10ps
module tb;
  localparam int MSC = 1; // One clock per millisecond keeps the run short
  localparam int DEBC = 3; // Shortened debounce window
  localparam logic [6:0] PAT [10] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d, 7'h07, 7'h7f, 7'h6f};
  // Sample time into clearance beside the whole seconds the count has dropped by then
  typedef struct packed {logic [15:0] at_ms; logic [7:0] sec;} pct_row_t;
  localparam pct_row_t ROWS [5] = '{'{16'h01f4, 8'h00}, '{16'h05dc, 8'h01}, '{16'h09c4, 8'h02}, '{16'h0ce4, 8'h03},
    '{16'h1450, 8'h05}};
  logic clk;
  logic reset;
  logic power_ok;
  logic walk;
  logic hand;
  logic [6:0] tens;
  logic [6:0] ones;
  logic count_on;
  int err_count;
  int check_count;
  pct_countdown #(.MS_CYCLES(MSC), .DEB_CYCLES(DEBC)) u_dut (.i_clk(clk), .i_reset(reset), .i_walk(walk),
    .i_hand(hand), .i_power_ok(power_ok), .o_seg_tens(tens), .o_seg_ones(ones), .o_count_on(count_on));
  pct_ctl_model #(.MS_CYCLES(MSC)) u_ctl (.i_clk(clk), .o_walk(walk), .o_hand(hand));
  // 100 MHz clock
  always #5 clk = ~clk;
  task automatic check(input logic [14:0] seen, input logic [14:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: display %h, wanted %h", $time, seen, exp);
    end
  endtask : check
  // Compare the display with a count; a negative count means dark
  task automatic look(input int cnt);
    logic [14:0] exp;
    exp = 15'h0000;
    if (cnt >= 0) exp = {1'b1, cnt >= 10 ? PAT[cnt / 10] : 7'h00, PAT[cnt % 10]};
    check({count_on, tens, ones}, exp);
  endtask : look
  task automatic wait_ms(input int ms);
    repeat (ms * MSC) @(negedge clk);
  endtask : wait_ms
  // One pedestrian cycle; shown is the learned count, negative for a dark cycle; b2b skips the steady hand
  task automatic cycle(input int walk_ms, input int clr_ms, input int shown, input bit b2b);
    int last;
    last = 0;
    u_ctl.show(1'b1, 1'b0, walk_ms);
    fork
      u_ctl.clear(clr_ms);
      for (int i = 0; i < 5; i++) begin
        if (int'(ROWS[i].at_ms) < clr_ms) begin
          wait_ms(int'(ROWS[i].at_ms) - last);
          last = int'(ROWS[i].at_ms);
          // A row past the learned count expects the change blanking
          look(shown < int'(ROWS[i].sec) ? -1 : shown - int'(ROWS[i].sec));
        end
      end
    join
    if (!b2b) begin
      // Steady hand needs a while to be told from a flash; look just after
      fork
        u_ctl.show(1'b0, 1'b1, 1400);
        begin
          wait_ms(1300);
          look(-1);
        end
      join
    end
    $display("cycle done at %0t, mismatches %0d", $time, err_count);
  endtask : cycle
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim
  // Watchdog at 100k clocks, a margin above the planned run of about 75k clocks
  initial begin
    #1000000;
    err_count++;
    $display("unexpected at %0t: run did not finish", $time);
    end_sim();
  end
  initial begin
    clk = 1'b0;
    reset = 1'b1;
    power_ok = 1'b1;
    err_count = 0;
    check_count = 0;
    repeat (16) @(negedge clk);
    look(-1);
    reset = 1'b0;
    cycle(1500, 3700, -1, 1'b0);
    cycle(1500, 3700, 3, 1'b0);
    cycle(1500, 3700, 3, 1'b1);
    cycle(300, 1700, 3, 1'b0);
    // Full walk with the flashing cut short: counting runs on and nothing is relearned
    cycle(1500, 1700, 3, 1'b0);
    // Cycle after the preemption, with a short supply dip mid count
    u_ctl.show(1'b1, 1'b0, 1500);
    fork
      u_ctl.clear(3700);
      begin
        wait_ms(500);
        look(3);
        wait_ms(700);
        power_ok = 1'b0;
        #1 look(-1);
        wait_ms(100);
        power_ok = 1'b1;
        wait_ms(200);
        look(2);
      end
    join
    u_ctl.show(1'b0, 1'b1, 1400);
    $display("power dip test done at %0t", $time);
    // Outage longer than the limit, then a dark cycle before counting resumes
    power_ok = 1'b0;
    u_ctl.show(1'b0, 1'b0, 1600);
    power_ok = 1'b1;
    cycle(1500, 3700, -1, 1'b0);
    cycle(1500, 3700, 3, 1'b0);
    // Clearance grows to 5 s: blank from 5 s, one dark relearn, then count from 5
    cycle(1500, 5700, 3, 1'b1);
    cycle(1500, 5700, -1, 1'b1);
    cycle(1500, 5700, 5, 1'b0);
    // Both indications dark in mid clearance
    u_ctl.show(1'b1, 1'b0, 1500);
    u_ctl.clear(1000);
    fork
      u_ctl.show(1'b0, 1'b0, 1400);
      begin
        wait_ms(1300);
        look(-1);
      end
    join
    $display("dark indication test done at %0t", $time);
    end_sim();
  end
endmodule : tb
